// ### rtl/imf_map.svh
`ifndef IMF_MAP_SVH
`define IMF_MAP_SVH
// Register byte offsets
`define IMF_OFF_CTRL   10'h000
`define IMF_OFF_LINK   10'h004
`define IMF_OFF_MSG    10'h008
`define IMF_OFF_NITEM  10'h00c
`define IMF_OFF_STAT   10'h010
// Item table window, 0x100 + 4*position
`define IMF_TBL_SEL    2'h1
// Control and link fields
`define IMF_CTRL_CMD   0
`define IMF_LINK_W     5
`define IMF_LINK_RST   5'h00
// Message config: rate[3:0] endian[4] opmode[7:5] edge[8] strobe pt[9]
// blend[11:10] accel unit[13:12] rate unit[15:14]
`define IMF_MSG_W      16
`define IMF_MSG_RST    16'h0005
`define IMF_MSG_LE     4
`define IMF_MSG_EDGE   8
`define IMF_MSG_MID    9
// Frame constants
`define IMF_SOM        16'h55aa
`define IMF_BODY_MAX   9'd400
`define IMF_ID_BIST_SU 8'h01
`define IMF_ID_BIST_OP 8'h02
`define IMF_ID_ERR_LO  8'h03
`define IMF_ID_ERR_HI  8'h07
`define IMF_ID_INERT   8'h20
`define IMF_ERR_BITS   80
// Validity strobe width
`define IMF_STROBE_NS  1000
`define IMF_CLK_NS     25
`define IMF_STROBE_CYC ((`IMF_STROBE_NS + `IMF_CLK_NS - 1) / `IMF_CLK_NS)
`endif

// ### rtl/imf_pkg.sv
package imf_pkg;
	// Unit mode state
	typedef enum logic {OPER, CMD} imf_mode_t;
	// Operating modes
	typedef enum logic [2:0] {OM_STREAM, OM_VSTROBE, OM_RST_TRIG, OM_SAMP_INERT,
		OM_SAMP_ALL, OM_START_TRIG} imf_opmode_t;
	// Parity choice
	typedef enum logic [1:0] {PAR_NONE, PAR_ODD, PAR_EVEN} imf_par_t;
	// Framer states
	typedef enum logic [2:0] {FS_IDLE, FS_HDR, FS_CNT, FS_ITEM, FS_LOAD, FS_BODY,
		FS_CSUM} imf_fs_t;
	// Serial transmitter states
	typedef enum logic [2:0] {US_IDLE, US_START, US_DATA, US_PAR, US_STOP} imf_us_t;
endpackage

// ### rtl/imf_framer.sv
`timescale 1ns/100ps
`include "imf_map.svh"
module imf_framer #(
	parameter int          CLK_HZ    = 40_000_000, // Core rate, scales timers
	parameter int          MAX_ITEMS = 64,         // Table depth, at most 64
	parameter logic        CSUM_XOR  = 1'b0,       // 0 byte sum, 1 rotate-xor
	parameter logic [15:0] CSUM_INIT = 16'h0000    // Checksum seed
)(
	// Clock, reset, enable
	input  wire logic        core_clk_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	// Register port
	input  wire logic [9:0]  reg_addr_i,
	input  wire logic [31:0] reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic      [31:0] reg_rdata_o,
	// Pins
	input  wire logic        trig_i,
	input  wire logic        suppress_i,
	output logic             tx_o,
	output logic             validity_strobe_p_o,
	output logic             validity_strobe_n_o,
	// Sensor side
	output logic      [7:0]  item_id_o,
	input  wire logic [31:0] item_data_i,
	input  wire logic        item_err_i,
	input  wire logic [15:0] bist_start_i,
	input  wire logic [15:0] bist_oper_i,
	output logic             sample_o,
	output logic             sample_all_o,
	output logic      [1:0]  blend_mode_o,
	output logic      [1:0]  acc_unit_o,
	output logic      [1:0]  rate_unit_o,
	output logic             cmd_mode_o
);
	// Rate period in cycles per selector
	function automatic logic [31:0] rate_period(input logic [3:0] sel);
		int hz;
		case (sel)
			4'h0: hz = 1;
			4'h1: hz = 5;
			4'h2: hz = 10;
			4'h3: hz = 20;
			4'h4: hz = 50;
			4'h5: hz = 100;
			4'h6: hz = 200;
			4'h7: hz = 500;
			4'h8: hz = 1000;
			default: hz = 2000;
		endcase
		return 32'(CLK_HZ / hz);
	endfunction

	// Bit period in cycles, rounded to nearest
	function automatic logic [8:0] baud_div(input logic [1:0] sel);
		int b;
		case (sel)
			2'h0: b = 115200;
			2'h1: b = 230400;
			2'h2: b = 460800;
			default: b = 921600;
		endcase
		return 9'((CLK_HZ + b / 2) / b);
	endfunction

	// Bytes per item id
	function automatic logic [2:0] item_len(input logic [7:0] id);
		if (id >= `IMF_ID_INERT)
			return 3'd4;
		else if (id >= `IMF_ID_BIST_SU && id <= `IMF_ID_ERR_HI)
			return 3'd2;
		return 3'd0;
	endfunction

	localparam logic [5:0] STROBE_CYC = 6'(`IMF_STROBE_CYC);

	// Configuration state
	imf_pkg::imf_mode_t     mode_ff, nxt_mode;
	logic [`IMF_LINK_W-1:0] link_ff, nxt_link;   // Baud, stop, parity
	logic [`IMF_MSG_W-1:0]  msg_ff, nxt_msg;     // Message settings
	logic [6:0]             nitem_ff, nxt_nitem; // Items in body
	logic [7:0]             tbl_ff [MAX_ITEMS];  // Item ids in send order
	logic [7:0]             nxt_tbl [MAX_ITEMS];
	logic [31:0]            rdata_ff, nxt_rdata;
	// Trigger, rate and strobe state
	logic                   trig_q_ff;
	logic [31:0]            tmr_ff, nxt_tmr;
	logic                   armed_ff, nxt_armed;
	logic [5:0]             stb_ff, nxt_stb;
	logic                   smp_ff, nxt_smp;
	// Framer state
	imf_pkg::imf_fs_t       fs_ff, nxt_fs;
	logic [1:0]             bi_ff, nxt_bi;      // Byte within field
	logic [2:0]             len_ff, nxt_len;    // Field length
	logic [31:0]            word_ff, nxt_word;  // Field value
	logic [6:0]             ii_ff, nxt_ii;      // Item position
	logic [8:0]             body_ff, nxt_body;  // Body bytes so far
	logic [15:0]            mcnt_ff, nxt_mcnt;  // Message count
	logic [15:0]            csum_ff, nxt_csum;
	logic [7:0]             cid_ff, nxt_cid;    // Item being fetched
	logic [`IMF_ERR_BITS-1:0] eacc_ff, nxt_eacc; // Errors of this message
	logic [`IMF_ERR_BITS-1:0] esnap_ff, nxt_esnap; // Errors last message
	// Serial transmitter state
	imf_pkg::imf_us_t       us_ff, nxt_us;
	logic [8:0]             div_ff, nxt_div;
	logic [2:0]             bit_ff, nxt_bit;
	logic [7:0]             sh_ff, nxt_sh;
	logic                   par_ff, nxt_par;
	logic                   stop_ff, nxt_stop;
	logic                   tx_ff, nxt_tx;
	// Decoded settings and events
	imf_pkg::imf_opmode_t   opm;
	imf_pkg::imf_par_t      parm;
	logic [31:0]            per;
	logic                   tick, edge_ev, req, go, fire, sending, tx_go, bdone;
	logic [7:0]             tbyte, tid;
	logic [2:0]             tlen;
	logic [1:0]             bsel;

	assign opm  = imf_pkg::imf_opmode_t'(msg_ff[7:5]);
	assign parm = imf_pkg::imf_par_t'(link_ff[4:3]);
	assign per  = rate_period(msg_ff[3:0]);
	assign tick = (tmr_ff >= per - 32'd1);
	assign edge_ev = msg_ff[`IMF_MSG_EDGE] ? (trig_q_ff & ~trig_i) : (~trig_q_ff & trig_i);

	// Configuration next state
	always_comb
	begin
		nxt_mode  = mode_ff;
		nxt_link  = link_ff;
		nxt_msg   = msg_ff;
		nxt_nitem = nitem_ff;
		nxt_tbl   = tbl_ff;
		nxt_rdata = 32'h0;
		if (reg_wr_i)
		begin
			if (reg_addr_i == `IMF_OFF_CTRL)
				nxt_mode = reg_wdata_i[`IMF_CTRL_CMD] ? imf_pkg::CMD : imf_pkg::OPER;
			else if (mode_ff == imf_pkg::CMD)
			begin
				if (reg_addr_i == `IMF_OFF_LINK)
					nxt_link = reg_wdata_i[`IMF_LINK_W-1:0];
				else if (reg_addr_i == `IMF_OFF_MSG)
					nxt_msg = reg_wdata_i[`IMF_MSG_W-1:0];
				else if (reg_addr_i == `IMF_OFF_NITEM)
					nxt_nitem = (reg_wdata_i > 32'(MAX_ITEMS)) ? 7'(MAX_ITEMS) : reg_wdata_i[6:0];
				else if (reg_addr_i[9:8] == `IMF_TBL_SEL && 32'(reg_addr_i[7:2]) < MAX_ITEMS)
					nxt_tbl[reg_addr_i[7:2]] = reg_wdata_i[7:0];
			end
		end
		// Unmapped reads return zero
		if (reg_rd_i)
		begin
			if (reg_addr_i == `IMF_OFF_CTRL)
				nxt_rdata = {31'h0, mode_ff == imf_pkg::CMD};
			else if (reg_addr_i == `IMF_OFF_LINK)
				nxt_rdata = 32'(link_ff);
			else if (reg_addr_i == `IMF_OFF_MSG)
				nxt_rdata = 32'(msg_ff);
			else if (reg_addr_i == `IMF_OFF_NITEM)
				nxt_rdata = 32'(nitem_ff);
			else if (reg_addr_i == `IMF_OFF_STAT)
				nxt_rdata = {mcnt_ff, 14'h0, fs_ff != imf_pkg::FS_IDLE, mode_ff == imf_pkg::CMD};
			else if (reg_addr_i[9:8] == `IMF_TBL_SEL && 32'(reg_addr_i[7:2]) < MAX_ITEMS)
				nxt_rdata = 32'(tbl_ff[reg_addr_i[7:2]]);
		end
	end

	// Configuration registers
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			mode_ff  <= imf_pkg::OPER;
			link_ff  <= `IMF_LINK_RST;
			msg_ff   <= `IMF_MSG_RST;
			nitem_ff <= 7'h00;
			tbl_ff   <= '{default: 8'h00};
			rdata_ff <= 32'h0;
		end
		else if (ce_i)
		begin
			mode_ff  <= nxt_mode;
			link_ff  <= nxt_link;
			msg_ff   <= nxt_msg;
			nitem_ff <= nxt_nitem;
			tbl_ff   <= nxt_tbl;
			rdata_ff <= nxt_rdata;
		end
	end

	// Message requests per operating mode
	always_comb
	begin
		nxt_tmr   = tick ? 32'h0 : tmr_ff + 32'd1;
		nxt_armed = armed_ff;
		req       = 1'b0;
		// mode decides what starts a message
		case (opm)
			imf_pkg::OM_STREAM,
			imf_pkg::OM_VSTROBE:
				req = tick;
			imf_pkg::OM_RST_TRIG:
			begin
				req = tick | edge_ev;
				if (edge_ev)
					nxt_tmr = 32'h0;
			end
			imf_pkg::OM_SAMP_INERT,
			imf_pkg::OM_SAMP_ALL:
				req = edge_ev;
			imf_pkg::OM_START_TRIG:
			begin
				req = tick & armed_ff;
				if (edge_ev)
					nxt_armed = 1'b1;
			end
			default:
				req = 1'b0;
		endcase
		// Timer and arming restart when leaving command state
		if (mode_ff == imf_pkg::CMD)
		begin
			nxt_tmr   = 32'h0;
			nxt_armed = 1'b0;
			req       = 1'b0;
		end
		fire = (opm == imf_pkg::OM_VSTROBE) && (mode_ff == imf_pkg::OPER)
			&& (msg_ff[`IMF_MSG_MID] ? (tmr_ff == (per >> 1)) : tick);
		nxt_stb = fire ? STROBE_CYC : ((stb_ff != 6'h0) ? stb_ff - 6'h1 : 6'h0);
		nxt_smp = req && (opm == imf_pkg::OM_SAMP_INERT || opm == imf_pkg::OM_SAMP_ALL);
		// operational only, suppress drops the request
		go = req && !suppress_i && fs_ff == imf_pkg::FS_IDLE;
	end

	// Trigger and timing registers
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			trig_q_ff <= 1'b0;
			tmr_ff    <= 32'h0;
			armed_ff  <= 1'b0;
			stb_ff    <= 6'h0;
			smp_ff    <= 1'b0;
		end
		else if (ce_i)
		begin
			trig_q_ff <= trig_i;
			tmr_ff    <= nxt_tmr;
			armed_ff  <= nxt_armed;
			stb_ff    <= nxt_stb;
			smp_ff    <= nxt_smp;
		end
	end

	// Byte currently offered to the transmitter
	always_comb
	begin
		// header stays big endian, rest follows setting
		if (fs_ff == imf_pkg::FS_HDR || !msg_ff[`IMF_MSG_LE])
			bsel = 2'(len_ff - 3'd1 - 3'(bi_ff));
		else
			bsel = bi_ff;
		tbyte = word_ff[8*bsel +: 8];
	end

	assign sending = fs_ff == imf_pkg::FS_HDR || fs_ff == imf_pkg::FS_CNT
		|| fs_ff == imf_pkg::FS_BODY || fs_ff == imf_pkg::FS_CSUM;
	assign tx_go = sending && us_ff == imf_pkg::US_IDLE;
	assign tid   = tbl_ff[ii_ff[5:0]];
	assign tlen  = item_len(tid);

	// Framer next state
	always_comb
	begin
		nxt_fs    = fs_ff;
		nxt_bi    = bi_ff;
		nxt_len   = len_ff;
		nxt_word  = word_ff;
		nxt_ii    = ii_ff;
		nxt_body  = body_ff;
		nxt_mcnt  = mcnt_ff;
		nxt_csum  = csum_ff;
		nxt_cid   = cid_ff;
		nxt_eacc  = eacc_ff;
		nxt_esnap = esnap_ff;
		bdone     = tx_go && (3'(bi_ff) == len_ff - 3'd1);
		if (tx_go && (fs_ff == imf_pkg::FS_CNT || fs_ff == imf_pkg::FS_BODY))
			nxt_csum = CSUM_XOR ? ({csum_ff[14:0], csum_ff[15]} ^ {8'h00, tbyte})
				: (csum_ff + {8'h00, tbyte});
		if (tx_go)
			nxt_bi = bi_ff + 2'd1;
		case (fs_ff)
			imf_pkg::FS_IDLE:
				if (go)
				begin
					nxt_fs   = imf_pkg::FS_HDR;
					nxt_word = {16'h0, `IMF_SOM};
					nxt_len  = 3'd2;
					nxt_bi   = 2'd0;
					nxt_ii   = 7'h0;
					nxt_body = 9'h0;
					nxt_csum = CSUM_INIT;
					nxt_eacc = '0;
				end
			imf_pkg::FS_HDR:
				if (bdone)
				begin
					nxt_fs   = imf_pkg::FS_CNT;
					nxt_word = {16'h0, mcnt_ff};
					nxt_bi   = 2'd0;
				end
			imf_pkg::FS_CNT:
				if (bdone)
					nxt_fs = imf_pkg::FS_ITEM;
			imf_pkg::FS_ITEM:
				// stop before body passes its limit
				if (ii_ff >= nitem_ff || body_ff + 9'(tlen) > `IMF_BODY_MAX)
				begin
					nxt_fs   = imf_pkg::FS_CSUM;
					nxt_word = {16'h0, csum_ff};
					nxt_len  = 3'd2;
					nxt_bi   = 2'd0;
				end
				else if (tlen == 3'd0)
					nxt_ii = ii_ff + 7'd1;
				else
				begin
					nxt_fs  = imf_pkg::FS_LOAD;
					nxt_cid = tid;
					nxt_len = tlen;
				end
			imf_pkg::FS_LOAD:
			begin
				if (cid_ff == `IMF_ID_BIST_SU)
					nxt_word = {16'h0, bist_start_i};
				else if (cid_ff == `IMF_ID_BIST_OP)
					nxt_word = {16'h0, bist_oper_i};
				else if (cid_ff <= `IMF_ID_ERR_HI)
					nxt_word = {16'h0, esnap_ff[16*(cid_ff-`IMF_ID_ERR_LO) +: 16]};
				else
					nxt_word = item_data_i;
				nxt_eacc[ii_ff] = item_err_i;
				nxt_body = body_ff + 9'(len_ff);
				nxt_bi   = 2'd0;
				nxt_fs   = imf_pkg::FS_BODY;
			end
			imf_pkg::FS_BODY:
				if (bdone)
				begin
					nxt_ii = ii_ff + 7'd1;
					nxt_fs = imf_pkg::FS_ITEM;
				end
			imf_pkg::FS_CSUM:
				if (bdone)
				begin
					nxt_fs    = imf_pkg::FS_IDLE;
					nxt_mcnt  = mcnt_ff + 16'd1;
					nxt_esnap = eacc_ff;
				end
			default:
				nxt_fs = imf_pkg::FS_IDLE;
		endcase
	end

	// Framer registers
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			fs_ff    <= imf_pkg::FS_IDLE;
			bi_ff    <= 2'd0;
			len_ff   <= 3'd0;
			word_ff  <= 32'h0;
			ii_ff    <= 7'h0;
			body_ff  <= 9'h0;
			mcnt_ff  <= 16'h0;
			csum_ff  <= 16'h0;
			cid_ff   <= 8'h0;
			eacc_ff  <= '0;
			esnap_ff <= '0;
		end
		else if (ce_i)
		begin
			fs_ff    <= nxt_fs;
			bi_ff    <= nxt_bi;
			len_ff   <= nxt_len;
			word_ff  <= nxt_word;
			ii_ff    <= nxt_ii;
			body_ff  <= nxt_body;
			mcnt_ff  <= nxt_mcnt;
			csum_ff  <= nxt_csum;
			cid_ff   <= nxt_cid;
			eacc_ff  <= nxt_eacc;
			esnap_ff <= nxt_esnap;
		end
	end

	// Serial transmitter next state
	always_comb
	begin
		nxt_us   = us_ff;
		nxt_div  = div_ff + 9'd1;
		nxt_bit  = bit_ff;
		nxt_sh   = sh_ff;
		nxt_par  = par_ff;
		nxt_stop = stop_ff;
		nxt_tx   = tx_ff;
		if (div_ff >= baud_div(link_ff[1:0]) - 9'd1 || us_ff == imf_pkg::US_IDLE)
			nxt_div = 9'h0;
		case (us_ff)
			imf_pkg::US_IDLE:
				if (tx_go)
				begin
					nxt_us  = imf_pkg::US_START;
					nxt_sh  = tbyte;
					nxt_par = ^tbyte;
					nxt_tx  = 1'b0;
					nxt_bit = 3'd0;
				end
			imf_pkg::US_START:
				if (nxt_div == 9'h0)
				begin
					nxt_us = imf_pkg::US_DATA;
					nxt_tx = sh_ff[0];
				end
			imf_pkg::US_DATA:
				if (nxt_div == 9'h0)
				begin
					nxt_sh  = {1'b0, sh_ff[7:1]};
					nxt_bit = bit_ff + 3'd1;
					nxt_tx  = sh_ff[1];
					if (bit_ff == 3'd7)
					begin
						// odd parity makes total ones odd
						nxt_us   = (parm == imf_pkg::PAR_NONE) ? imf_pkg::US_STOP : imf_pkg::US_PAR;
						nxt_tx   = (parm == imf_pkg::PAR_NONE) | (par_ff ^ (parm == imf_pkg::PAR_ODD));
						nxt_stop = link_ff[2];
					end
				end
			imf_pkg::US_PAR:
				if (nxt_div == 9'h0)
				begin
					nxt_us = imf_pkg::US_STOP;
					nxt_tx = 1'b1;
				end
			imf_pkg::US_STOP:
				if (nxt_div == 9'h0)
				begin
					if (stop_ff)
						nxt_stop = 1'b0;
					else
						nxt_us = imf_pkg::US_IDLE;
				end
			default:
				nxt_us = imf_pkg::US_IDLE;
		endcase
	end

	// Serial transmitter registers
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			us_ff   <= imf_pkg::US_IDLE;
			div_ff  <= 9'h0;
			bit_ff  <= 3'd0;
			sh_ff   <= 8'h0;
			par_ff  <= 1'b0;
			stop_ff <= 1'b0;
			tx_ff   <= 1'b1;
		end
		else if (ce_i)
		begin
			us_ff   <= nxt_us;
			div_ff  <= nxt_div;
			bit_ff  <= nxt_bit;
			sh_ff   <= nxt_sh;
			par_ff  <= nxt_par;
			stop_ff <= nxt_stop;
			tx_ff   <= nxt_tx;
		end
	end

	// Outputs; differential strobe pair
	assign validity_strobe_p_o = stb_ff != 6'h0;
	assign validity_strobe_n_o = stb_ff == 6'h0;
	assign tx_o         = tx_ff;
	assign reg_rdata_o  = rdata_ff;
	assign item_id_o    = cid_ff;
	assign sample_o     = smp_ff;
	assign sample_all_o = opm == imf_pkg::OM_SAMP_ALL;
	assign cmd_mode_o   = mode_ff == imf_pkg::CMD;
	// blend and units to the arithmetic
	assign blend_mode_o = msg_ff[11:10];
	assign acc_unit_o   = msg_ff[13:12];
	assign rate_unit_o  = msg_ff[15:14];

	// Checks
	a_mode_reset:
	assert property (@(posedge core_clk_i) $fell(rst_i) |-> mode_ff == imf_pkg::OPER)
		else $error("not operational after reset");
	a_supp_hold:
	assert property (@(posedge core_clk_i) disable iff (rst_i)
		(fs_ff == imf_pkg::FS_IDLE && suppress_i) |=> fs_ff == imf_pkg::FS_IDLE)
		else $error("message began while suppressed");
	a_mode_stable:
	assert property (@(posedge core_clk_i) disable iff (rst_i)
		!(reg_wr_i && reg_addr_i == `IMF_OFF_CTRL) |=> $stable(mode_ff))
		else $error("state changed without control write");
	a_cfg_locked:
	assert property (@(posedge core_clk_i) disable iff (rst_i)
		(mode_ff == imf_pkg::OPER && !(reg_wr_i && reg_addr_i == `IMF_OFF_CTRL))
		|=> $stable(msg_ff) && $stable(link_ff))
		else $error("settings changed in operational state");
	a_hdr_first:
	assert property (@(posedge core_clk_i) disable iff (rst_i)
		(go && ce_i) |=> fs_ff == imf_pkg::FS_HDR && word_ff[15:0] == `IMF_SOM)
		else $error("message not opened by marker");
	a_count_step:
	assert property (@(posedge core_clk_i) disable iff (rst_i)
		(fs_ff == imf_pkg::FS_CSUM && bdone && ce_i) |=> mcnt_ff == $past(mcnt_ff) + 16'd1)
		else $error("message count not advanced");
	a_body_limit:
	assert property (@(posedge core_clk_i) disable iff (rst_i) body_ff <= `IMF_BODY_MAX)
		else $error("body longer than limit");
	a_idle_line:
	assert property (@(posedge core_clk_i) disable iff (rst_i)
		(us_ff == imf_pkg::US_STOP || us_ff == imf_pkg::US_IDLE) |-> tx_o)
		else $error("line low in stop or idle");
	a_strobe_fire:
	assert property (@(posedge core_clk_i) disable iff (rst_i)
		(fire && ce_i) |=> validity_strobe_p_o && !validity_strobe_n_o)
		else $error("strobe not raised");
endmodule

// ### test/imf_host_rx.sv
`timescale 1ns/100ps
// Host receiver: decodes bytes on the line at the agreed format
module imf_host_rx (
	// Clock and serial line
	input  wire logic       clk_i,
	input  wire logic       line_i,
	// Agreed link format
	input  wire logic [5:0] bit_cyc_i,
	input  wire logic [1:0] par_i,
	input  wire logic       two_stop_i,
	// Decoded bytes, bad flag is sticky
	output logic      [7:0] byte_o,
	output logic            stb_o,
	output logic            bad_o
);
	logic [7:0] sh;  // Shift of data bits
	// Samples each bit at its middle; no resync inside a byte
	initial
	begin
		stb_o = 1'b0;
		bad_o = 1'b0;
		byte_o = 8'h00;
		forever
		begin
			@(negedge line_i);
			repeat (bit_cyc_i / 2) @(posedge clk_i);
			for (int i = 0; i < 8; i++)
			begin
				repeat (bit_cyc_i) @(posedge clk_i);
				sh[i] = line_i;
			end
			if (par_i != 2'h0)
			begin
				repeat (bit_cyc_i) @(posedge clk_i);
				if (line_i !== ((^sh) ^ (par_i == 2'h1)))
					bad_o = 1'b1;
			end
			for (int i = 0; i <= int'(two_stop_i); i++)
			begin
				repeat (bit_cyc_i) @(posedge clk_i);
				if (line_i !== 1'b1)
					bad_o = 1'b1;
			end
			byte_o <= sh;
			stb_o <= 1'b1;
			@(posedge clk_i);
			stb_o <= 1'b0;
		end
	end
endmodule

// ### test/imf_message_framer_tb.sv
`timescale 1ns/100ps
`include "imf_map.svh"
module imf_message_framer_tb;
	// Bench drive and observe
	logic        core_clk_i = 1'b0, rst_i = 1'b1, trig_i = 1'b0, suppress_i = 1'b0;
	logic        reg_wr_i = 1'b0, reg_rd_i = 1'b0, ts = 1'b0;
	logic [9:0]  reg_addr_i = 10'h000;
	logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, rv;
	logic        tx_o, vp, vn, sample_o, sample_all_o, cmd_mode_o, rx_stb, rx_bad;
	logic [7:0]  item_id_o, rx_byte, e[14];
	logic [1:0]  blend_mode_o, acc_unit_o, rate_unit_o, pr = 2'h0;
	logic [5:0]  bc = 6'd4;
	logic [15:0] cnt[2];
	int          err_total = 0, n_tests = 0, cyc = 0, w, rw, fw;
	logic [7:0]  q[$];
	int          tq[$];
	// 40 MHz core clock
	always #12.5 core_clk_i = ~core_clk_i;
	// Rate timers scaled down tenfold to keep the run short
	imf_framer #(.CLK_HZ(4_000_000)) uut (.core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(1'b1),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .trig_i(trig_i),
		.suppress_i(suppress_i), .tx_o(tx_o), .validity_strobe_p_o(vp),
		.validity_strobe_n_o(vn), .item_id_o(item_id_o),
		.item_data_i({24'ha1b2c3, item_id_o}), .item_err_i(item_id_o == 8'h20),
		.bist_start_i(16'hbe5a), .bist_oper_i(16'h0000), .sample_o(sample_o),
		.sample_all_o(sample_all_o), .blend_mode_o(blend_mode_o),
		.acc_unit_o(acc_unit_o), .rate_unit_o(rate_unit_o), .cmd_mode_o(cmd_mode_o));
	imf_host_rx host (.clk_i(core_clk_i), .line_i(tx_o), .bit_cyc_i(bc), .par_i(pr),
		.two_stop_i(ts), .byte_o(rx_byte), .stb_o(rx_stb), .bad_o(rx_bad));
	// Byte log with arrival cycle; hang guard
	always @(posedge core_clk_i)
	begin
		cyc <= cyc + 1;
		if (rx_stb === 1'b1)
		begin
			q.push_back(rx_byte);
			tq.push_back(cyc);
		end
		if (cyc == 99000)
		begin
			err_total++;
			summarize();
		end
	end
	task automatic summarize;
		$display("tests %0d errors %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		n_tests++;
		if (s !== x)
		begin
			err_total++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask
	// Gap cycle after each write keeps one assignment per step
	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge core_clk_i);
		reg_wr_i <= 1'b0;
		@(posedge core_clk_i);
	endtask
	task automatic rd(input logic [9:0] a);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge core_clk_i);
		reg_rd_i <= 1'b0;
		@(negedge core_clk_i);
		rv = reg_rdata_o;
		@(posedge core_clk_i);
	endtask
	task automatic get(input int n);
		for (int i = 0; i < 9000 && q.size() < n; i++)
			@(posedge core_clk_i);
		chk(32'(q.size() >= n), 32'h1);
	endtask
	// Field into expected frame, endian chosen
	task automatic fld(input int p, input logic [31:0] v, input int n, input bit le);
		for (int i = 0; i < n; i++)
			e[p + i] = le ? v[8 * i +: 8] : v[8 * (n - 1 - i) +: 8];
	endtask
	// Configure in command state, then go operational
	task automatic go(input logic [4:0] l, input logic [15:0] m);
		int b;
		b = 115200 << l[1:0];
		bc = 6'((4_000_000 + b / 2) / b);
		pr = l[4:3];
		ts = l[2];
		wr(`IMF_OFF_LINK, 32'(l));
		wr(`IMF_OFF_MSG, 32'(m));
		wr(`IMF_OFF_NITEM, 32'h3);
		wr(10'h100, 32'h01);
		wr(10'h104, 32'h20);
		wr(10'h108, 32'h03);
		rd(`IMF_OFF_MSG);
		chk(rv, 32'(m));
		q.delete();
		tq.delete();
		wr(`IMF_OFF_CTRL, 32'h0);
	endtask
	// Suppress, drain, prove silence, then back to command state
	task automatic to_cmd;
		suppress_i <= 1'b1;
		for (int i = 0; i < 3000; i++)
		begin
			rd(`IMF_OFF_STAT);
			if (rv[1] === 1'b0)
				break;
		end
		repeat (400) @(posedge core_clk_i);
		q.delete();
		repeat (2100) @(posedge core_clk_i);
		chk(q.size(), 0);
		chk(cmd_mode_o, 1'b0);
		wr(`IMF_OFF_CTRL, 32'h1);
		suppress_i <= 1'b0;
		chk(cmd_mode_o, 1'b1);
	endtask
	// Two frames: second checked byte by byte
	task automatic chkfr(input bit le);
		logic [15:0] cs;
		for (int k = 0; k < 2; k++)
			cnt[k] = le ? {q[14 * k + 3], q[14 * k + 2]} : {q[14 * k + 2], q[14 * k + 3]};
		e[0] = 8'h55;
		e[1] = 8'haa;
		fld(2, cnt[1], 2, le);
		fld(4, 32'hbe5a, 2, le);
		fld(6, 32'ha1b2c320, 4, le);
		fld(10, 32'h0002, 2, le);
		cs = 16'h0000;
		for (int i = 2; i < 12; i++)
			cs += e[i];
		fld(12, cs, 2, le);
		chk(cnt[1], 16'(cnt[0] + 16'h1));
		for (int i = 0; i < 14; i++)
			chk(q[14 + i], e[i]);
		chk(tq[14] - tq[0], 2000);
	endtask
	// Main sequence
	initial
	begin
		repeat (6) @(posedge core_clk_i);
		rst_i <= 1'b0;
		@(posedge core_clk_i);
		chk({tx_o, vp, vn, cmd_mode_o}, 4'b1010);
		wr(`IMF_OFF_MSG, 32'h0fff);
		rd(`IMF_OFF_MSG);
		chk(rv, 32'h0005);
		rd(10'h3fc);
		chk(rv, 32'h0);
		wr(`IMF_OFF_CTRL, 32'h1);
		chk(cmd_mode_o, 1'b1);
		go(5'h03, 16'h0009);
		get(28);
		chkfr(1'b0);
		to_cmd();
		go(5'h03, 16'hd819);
		chk({blend_mode_o, acc_unit_o, rate_unit_o}, 6'h27);
		get(28);
		chkfr(1'b1);
		to_cmd();
		for (int k = 0; k < 4; k++)
		begin
			go(5'({2'(k % 3), k[0], 2'(k)}), 16'h0009);
			get(14);
			chk({q[0], q[1], 7'h0, rx_bad}, 24'h55aa00);
			to_cmd();
		end
		// Strobe at midpoint (line idle), then at start (frame opening)
		for (int s = 0; s < 2; s++)
		begin
			go(5'h03, (s == 0) ? 16'h0229 : 16'h0029);
			for (int i = 0; i < 2500 && vp !== 1'b1; i++)
				@(posedge core_clk_i);
			w = 0;
			rw = 0;
			while (vp === 1'b1 && w < 100)
			begin
				w++;
				rw += int'(tx_o === 1'b0);
				chk(vn, 1'b0);
				@(posedge core_clk_i);
			end
			chk(w, `IMF_STROBE_CYC);
			chk(32'(rw != 0), 32'(s == 1));
			to_cmd();
		end
		for (int j = 2; j < 6; j++)
		begin
			go(5'h03, 16'(9 | (j << 5) | (int'(j == 4) << 8)));
			chk(sample_all_o, 1'(j == 4));
			repeat ((j == 5) ? 2100 : 10) @(posedge core_clk_i);
			if (j == 5)
				chk(q.size(), 0);
			rw = 0;
			fw = 0;
			trig_i <= 1'b1;
			repeat (20) @(posedge core_clk_i) rw += int'(sample_o === 1'b1);
			trig_i <= 1'b0;
			repeat (20) @(posedge core_clk_i) fw += int'(sample_o === 1'b1);
			if (j == 3 || j == 4)
				chk({rw[7:0], fw[7:0]}, (j == 3) ? 16'h0100 : 16'h0001);
			else
			begin
				get(1);
				chk(q[0], 8'h55);
			end
			to_cmd();
		end
		summarize();
	end
endmodule
